//--- rtl/lpd_pkg.sv
package lpd_pkg;

  // entry and address geometry
  localparam int unsigned ENTRY_W     = 64;
  localparam int unsigned PA_W        = 52;
  localparam int unsigned PAGE_SHIFT  = 21;
  localparam logic [5:0]  HAW_CLIENT  = 6'h27;
  localparam logic [5:0]  HAW_SERVER  = 6'h2E;

  // entry field positions
  localparam int unsigned BIT_NO_RUN      = 63;
  localparam int unsigned BIT_RES_LO_TOP  = 20;
  localparam int unsigned BIT_RES_LO_BOT  = 13;
  localparam int unsigned BIT_CACHE_IDX   = 12;
  localparam int unsigned BIT_UNUSED      = 11;
  localparam int unsigned BIT_EXT_USE     = 10;
  localparam int unsigned BIT_IGN_LO      = 9;
  localparam int unsigned BIT_GLOBAL      = 8;
  localparam int unsigned BIT_PAGE_SIZE   = 7;
  localparam int unsigned BIT_DIRTY       = 6;
  localparam int unsigned BIT_ACCESSED    = 5;
  localparam int unsigned BIT_CACHE_OFF   = 4;
  localparam int unsigned BIT_WR_THROUGH  = 3;
  localparam int unsigned BIT_USER        = 2;
  localparam int unsigned BIT_WRITE       = 1;
  localparam int unsigned BIT_PRESENT     = 0;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FAULTS = 8'h08;

  // control register fields
  localparam int unsigned CTRL_NO_RUN_ON   = 0;
  localparam int unsigned CTRL_TWO_STAGE   = 1;
  localparam int unsigned CTRL_EXT_TRACK   = 2;
  localparam int unsigned CTRL_GLOBAL_ON   = 3;
  localparam int unsigned CTRL_SUP_WP_ON   = 4;
  localparam int unsigned CTRL_SERVER_CFG  = 5;
  localparam int unsigned CTRL_W           = 6;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;

  // status register fields (last completed walk)
  localparam int unsigned STAT_NOT_PRESENT = 0;
  localparam int unsigned STAT_BAD_FORMAT  = 1;
  localparam int unsigned STAT_DENIED      = 2;
  localparam int unsigned STAT_WROTE_BACK  = 3;
  localparam int unsigned STAT_W           = 4;

endpackage : lpd_pkg

//--- rtl/lpd_leaf_decoder.sv
`timescale 1ns/100ps
// Contract
// - no-run flag refuses execute when enabled
// - bits 62:52 and 9 ignored
// - address width 39 client, 46 server
// - frame base from entry bits 21 and up
// - nested mode marks address guest physical
// - set extended-use flag when tracking on
// - global bit gets no special treatment
// - successful write sets dirty flag
// - first access sets accessed flag
// - user bit zero blocks user requests
// - write bit zero denies user writes
// - every request checked as user privilege
// - bits 12,4,3 form memory-type index
// - bit 11 never used
module lpd_leaf_decoder
  import lpd_pkg::*;
(
  input  wire logic                 clk_sys_i,       // 250 MHz system clock
  input  wire logic                 rst_n_i,         // async reset, active low
  // register port
  input  wire logic [7:0]           reg_addr_i,      // byte address
  input  wire logic [31:0]          reg_wdata_i,     // write data
  input  wire logic                 reg_wr_i,        // write strobe
  input  wire logic                 reg_rd_i,        // read strobe
  output logic      [31:0]          reg_rdata_o,     // read data, one cycle later
  // translation request with the fetched leaf entry
  input  wire logic                 req_valid_i,     // request pulse
  input  wire logic                 req_write_i,     // request is a write
  input  wire logic                 req_exec_i,      // request is an instruction fetch
  input  wire logic [20:0]          req_offset_i,    // low address bits within page
  input  wire logic [ENTRY_W-1:0]   entry_i,         // leaf entry from table memory
  // translation answer
  output logic                      rsp_valid_o,     // answer pulse
  output logic                      rsp_fault_o,     // translation fault
  output logic                      rsp_denied_o,    // permission refused
  output logic      [PA_W-1:0]      rsp_addr_o,      // final address
  output logic                      guest_phys_addr_o, // address needs second stage
  output logic      [2:0]           rsp_mem_idx_o,   // memory-type lookup index
  // entry update toward table memory
  output logic                      wb_valid_o,      // entry must be written back
  output logic      [ENTRY_W-1:0]   wb_entry_o       // entry with flags updated
);

  ////////////////////////////////////////////////////////////////////////////
  // control and decode signals

  logic [CTRL_W-1:0] ctrl_q;          // software control bits
  logic [STAT_W-1:0] stat_q;          // outcome of last walk
  logic [31:0]       fault_cnt_q;     // faults and denials seen
  logic [5:0]        host_addr_width; // active address width
  logic [PA_W-1:0]   res_hi_mask;     // reserved bits above the address field
  logic              no_run_feature_on;
  logic              two_stage_translation_on;
  logic              extended_use_tracking_on;
  logic              global_pages_on;
  logic              supervisor_write_protect_on;
  logic              is_user;         // privilege of the checked request
  logic              not_present;     // present flag clear
  logic              bad_format;      // page size clear or reserved set
  logic              fault_c;         // walk aborts
  logic              user_deny;       // user access blocked
  logic              write_deny;      // write blocked
  logic              exec_deny;       // fetch blocked
  logic              denied_c;        // any permission refusal
  logic              ok_c;            // walk and check both pass
  logic [ENTRY_W-1:0] new_entry;      // entry with flags set

  assign no_run_feature_on           = ctrl_q[CTRL_NO_RUN_ON];
  assign two_stage_translation_on    = ctrl_q[CTRL_TWO_STAGE];
  assign extended_use_tracking_on    = ctrl_q[CTRL_EXT_TRACK];
  // stored for software only, global pages are not built here
  assign global_pages_on             = ctrl_q[CTRL_GLOBAL_ON];
  assign supervisor_write_protect_on = ctrl_q[CTRL_SUP_WP_ON];

  assign is_user = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // address width and reserved field mask

  assign host_addr_width = ctrl_q[CTRL_SERVER_CFG] ? HAW_SERVER : HAW_CLIENT;

  // one mask bit per entry bit below bit 52: reserved from the width up to bit 51
  for (genvar gi = 0; gi < PA_W; gi++) begin : g_mask
    assign res_hi_mask[gi] = (6'(gi) >= host_addr_width);
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry check

  assign not_present = ~entry_i[BIT_PRESENT];
  assign bad_format  = ~entry_i[BIT_PAGE_SIZE]
                     | (|(entry_i[PA_W-1:0] & res_hi_mask))
                     | (|entry_i[BIT_RES_LO_TOP:BIT_RES_LO_BOT]);
  assign fault_c     = not_present | bad_format;

  assign user_deny  = is_user & ~entry_i[BIT_USER];
  assign write_deny = req_write_i & ~entry_i[BIT_WRITE]
                    & (is_user | supervisor_write_protect_on);
  assign exec_deny  = req_exec_i & no_run_feature_on & entry_i[BIT_NO_RUN];
  assign denied_c   = user_deny | write_deny | exec_deny;
  assign ok_c       = ~fault_c & ~denied_c;

  // flag updates, only on a walk that yields an address
  always_comb begin
    new_entry = entry_i;
    if (ok_c) begin
      new_entry[BIT_ACCESSED] = 1'b1;
    end
    if (ok_c && req_write_i) begin
      new_entry[BIT_DIRTY] = 1'b1;
    end
    if (ok_c && extended_use_tracking_on) begin
      new_entry[BIT_EXT_USE] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer registers

  // answer one cycle after each request
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o  <= 1'b0;
      rsp_fault_o  <= 1'b0;
      rsp_denied_o <= 1'b0;
    end else begin
      rsp_valid_o  <= req_valid_i;
      rsp_fault_o  <= req_valid_i & fault_c;
      // a fault hides any permission outcome
      rsp_denied_o <= req_valid_i & ~fault_c & denied_c;
    end
  end

  // final address and attributes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_addr_o        <= '0;
      guest_phys_addr_o <= 1'b0;
      rsp_mem_idx_o     <= 3'h0;
    end else if (req_valid_i) begin
      if (ok_c) begin
        rsp_addr_o <= {entry_i[PA_W-1:PAGE_SHIFT], req_offset_i};
      end else begin
        rsp_addr_o <= '0;
      end
      guest_phys_addr_o <= ok_c & two_stage_translation_on;
      rsp_mem_idx_o <= {entry_i[BIT_CACHE_IDX], entry_i[BIT_CACHE_OFF],
                        entry_i[BIT_WR_THROUGH]};
    end
  end

  // write back only when a flag actually changed, saving table traffic
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_valid_o <= 1'b0;
      wb_entry_o <= '0;
    end else begin
      wb_valid_o <= req_valid_i & (new_entry != entry_i);
      if (req_valid_i) begin
        wb_entry_o <= new_entry;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  // control register write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      ctrl_q <= reg_wdata_i[CTRL_W-1:0];
    end
  end

  // last walk outcome
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= '0;
    end else if (req_valid_i) begin
      stat_q[STAT_NOT_PRESENT] <= not_present;
      stat_q[STAT_BAD_FORMAT]  <= bad_format;
      stat_q[STAT_DENIED]      <= ~fault_c & denied_c;
      stat_q[STAT_WROTE_BACK]  <= new_entry != entry_i;
    end
  end

  // fault counter, a write clears it; a count in the same cycle restarts it at one
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_cnt_q <= '0;
    end else if (req_valid_i && !ok_c) begin
      fault_cnt_q <= (reg_wr_i && reg_addr_i == REG_FAULTS) ? 32'h1 : fault_cnt_q + 32'h1;
    end else if (reg_wr_i && reg_addr_i == REG_FAULTS) begin
      fault_cnt_q <= '0;
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL:   reg_rdata_o <= {26'h0, ctrl_q};
        REG_STATUS: reg_rdata_o <= {28'h0, stat_q};
        REG_FAULTS: reg_rdata_o <= fault_cnt_q;
        default:    reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // a clean answer following a request
  sequence s_good_rsp;
    rsp_valid_o && !rsp_fault_o && !rsp_denied_o;
  endsequence

  sequence s_write_req;
    req_valid_i && req_write_i;
  endsequence

  property p_rsp_timing;
    req_valid_i |=> rsp_valid_o;
  endproperty
  a_rsp_timing: assert property (p_rsp_timing)
    else $error("answer missing one cycle after request");

  property p_no_spurious;
    !req_valid_i |=> !rsp_valid_o && !wb_valid_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer without request");

  property p_no_run;
    req_valid_i && req_exec_i && no_run_feature_on && entry_i[BIT_NO_RUN]
      |=> rsp_fault_o || rsp_denied_o;
  endproperty
  a_no_run: assert property (p_no_run)
    else $error("fetch allowed on no-run page");

  property p_not_present;
    req_valid_i && !entry_i[BIT_PRESENT] |=> rsp_fault_o && rsp_addr_o == '0;
  endproperty
  a_not_present: assert property (p_not_present)
    else $error("missing fault on absent entry");

  property p_reserved_lo;
    req_valid_i && (|entry_i[BIT_RES_LO_TOP:BIT_RES_LO_BOT]) |=> rsp_fault_o;
  endproperty
  a_reserved_lo: assert property (p_reserved_lo)
    else $error("reserved low bits accepted");

  property p_user_block;
    req_valid_i && !entry_i[BIT_USER] |=> rsp_fault_o || rsp_denied_o;
  endproperty
  a_user_block: assert property (p_user_block)
    else $error("user request passed with user bit clear");

  property p_write_block;
    req_valid_i && req_write_i && !entry_i[BIT_WRITE] |=> rsp_fault_o || rsp_denied_o;
  endproperty
  a_write_block: assert property (p_write_block)
    else $error("write passed with write bit clear");

  property p_dirty;
    s_write_req ##1 s_good_rsp |-> wb_entry_o[BIT_DIRTY] && wb_entry_o[BIT_ACCESSED];
  endproperty
  a_dirty: assert property (p_dirty)
    else $error("dirty flag not set on write");

  property p_accessed;
    req_valid_i && !entry_i[BIT_ACCESSED] ##1 s_good_rsp |-> wb_valid_o;
  endproperty
  a_accessed: assert property (p_accessed)
    else $error("accessed flag update not issued");

  property p_ext_use;
    req_valid_i && extended_use_tracking_on ##1 s_good_rsp |-> wb_entry_o[BIT_EXT_USE];
  endproperty
  a_ext_use: assert property (p_ext_use)
    else $error("extended-use flag not set");

  property p_addr_join;
    req_valid_i ##1 s_good_rsp |-> rsp_addr_o[PAGE_SHIFT-1:0] == $past(req_offset_i)
      && rsp_addr_o[PA_W-1:PAGE_SHIFT] == $past(entry_i[PA_W-1:PAGE_SHIFT]);
  endproperty
  a_addr_join: assert property (p_addr_join)
    else $error("final address not base joined with offset");

  // index bits pass through whatever the walk outcome
  property p_mem_idx;
    req_valid_i |=> rsp_mem_idx_o[2] == $past(entry_i[BIT_CACHE_IDX])
      && rsp_mem_idx_o[1:0] == $past({entry_i[BIT_CACHE_OFF], entry_i[BIT_WR_THROUGH]});
  endproperty
  a_mem_idx: assert property (p_mem_idx)
    else $error("memory-type index not taken from entry");

  property p_guest;
    req_valid_i ##1 s_good_rsp |-> guest_phys_addr_o == $past(two_stage_translation_on);
  endproperty
  a_guest: assert property (p_guest)
    else $error("guest physical marking wrong");

  // global pages on must leave the global bit untouched
  property p_global_inert;
    req_valid_i && global_pages_on |=> wb_entry_o[BIT_GLOBAL] == $past(entry_i[BIT_GLOBAL]);
  endproperty
  a_global_inert: assert property (p_global_inert)
    else $error("global bit altered");

  // ignored and unused bits travel back to the table as they came
  property p_ignored;
    req_valid_i |=> wb_entry_o[BIT_NO_RUN-1:PA_W] == $past(entry_i[BIT_NO_RUN-1:PA_W])
      && wb_entry_o[BIT_UNUSED] == $past(entry_i[BIT_UNUSED])
      && wb_entry_o[BIT_IGN_LO] == $past(entry_i[BIT_IGN_LO]);
  endproperty
  a_ignored: assert property (p_ignored)
    else $error("ignored entry bits altered");

endmodule // lpd_leaf_decoder

//--- bench/lpd_table_mem.sv
`timescale 1ns/100ps
// page-table memory model: serves leaf entries, takes write-backs
module lpd_table_mem
  import lpd_pkg::*;
(
  input  wire logic               clk_sys_i,  // system clock
  input  wire logic               req_i,      // entry is being fetched
  input  wire logic [3:0]         idx_i,      // slot of the entry
  input  wire logic               wb_valid_i, // write-back strobe
  input  wire logic [ENTRY_W-1:0] wb_entry_i, // entry with flags updated
  output logic      [ENTRY_W-1:0] entry_o     // entry toward the walker
);
  logic [ENTRY_W-1:0] mem [16];  // table slots, filled by the bench
  logic [3:0]         last_q;    // slot of the walk in flight
  // no fetch: show the inverse so a stale entry never passes
  assign entry_o = req_i ? mem[idx_i] : ~mem[idx_i];
  // write-back lands in the slot of the last fetch
  always @(posedge clk_sys_i) begin
    if (req_i) last_q <= idx_i;
    if (wb_valid_i) mem[last_q] <= wb_entry_i;
  end
endmodule // lpd_table_mem

//--- bench/lpd_leaf_decoder_tb_top.sv
`timescale 1ns/100ps
module lpd_leaf_decoder_tb_top
  import lpd_pkg::*;
;
  typedef struct packed {
    logic fault, denied, np, guest, wbv;
    logic [PA_W-1:0] addr;
    logic [2:0] idx;
    logic [ENTRY_W-1:0] wbe;
  } lpd_exp_s;  // one expected answer
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_pend = 1'h0;
  logic req_valid = 1'h0, req_write = 1'h0, req_exec = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [20:0] req_offset = 21'h0;
  logic [3:0] tidx = 4'h0;
  logic [5:0] ctrl_q = 6'h00, c;  // shadow of the control register
  logic [ENTRY_W-1:0] entry, wb_entry, e;
  logic rsp_valid, rsp_fault, rsp_denied, guest, wb_valid, w, x;
  logic [PA_W-1:0] rsp_addr;
  logic [2:0] mem_idx;
  lpd_exp_s eq[$], r, got;  // pending walk answers; got belongs to the monitor alone
  logic [31:0] rq[$];  // pending read data
  int bad_count = 0, comparisons = 0, nfault = 0;
  always #2 clk = ~clk;
  lpd_leaf_decoder dut (.clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .req_valid_i(req_valid), .req_write_i(req_write), .req_exec_i(req_exec),
    .req_offset_i(req_offset), .entry_i(entry), .rsp_valid_o(rsp_valid),
    .rsp_fault_o(rsp_fault), .rsp_denied_o(rsp_denied), .rsp_addr_o(rsp_addr),
    .guest_phys_addr_o(guest), .rsp_mem_idx_o(mem_idx), .wb_valid_o(wb_valid),
    .wb_entry_o(wb_entry));
  lpd_table_mem tm (.clk_sys_i(clk), .req_i(req_valid), .idx_i(tidx),
    .wb_valid_i(wb_valid), .wb_entry_i(wb_entry), .entry_o(entry));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // expected walk outcome, from the entry format and the control shadow ctrl_q
  function automatic lpd_exp_s predict(logic [63:0] e, logic w, logic x, logic [20:0] off);
    lpd_exp_s p;
    logic [63:0] m;
    logic ok;
    m = 64'h0;
    m[20:13] = 8'hFF;
    for (int i = (ctrl_q[5] ? 46 : 39); i < 52; i++) m[i] = 1'h1;
    p.np = !e[0];
    p.fault = !e[0] || !e[7] || ((e & m) != 64'h0);
    p.denied = !p.fault && (!e[2] || (w && !e[1]) || (x && ctrl_q[0] && e[63]));
    ok = !p.fault && !p.denied;
    p.addr = ok ? {e[51:21], off} : '0;
    p.guest = ok && ctrl_q[1];
    p.idx = {e[12], e[4], e[3]};
    // accessed at 5, dirty at 6, extended-use at 10
    p.wbe = e | (ok ? {53'h0, ctrl_q[2], 3'h0, w, 1'h1, 5'h0} : 64'h0);
    p.wbv = ok && (p.wbe != e);
    return p;
  endfunction
  // register bus: one-cycle strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == REG_CTRL) ctrl_q = d[5:0];
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    rq.push_back(want);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask
  // one walk request; left raised so walks run back to back
  task automatic walk(input logic [3:0] k, input logic w, input logic x, output lpd_exp_s p);
    logic [20:0] off;
    off = 21'($urandom);
    @(negedge clk);
    p = predict(tm.mem[k], w, x, off);
    eq.push_back(p);
    nfault += int'(p.fault || p.denied);
    @(posedge clk);
    {req_valid, tidx, req_write, req_exec, req_offset} <= {1'h1, k, w, x, off};
  endtask
  task automatic idle();
    @(posedge clk);
    req_valid <= 1'h0;
  endtask
  // directed entries: good page with chosen entry fields, control bits or request kind changed
  function automatic void pick(input int i, output logic [63:0] e, output logic [5:0] c,
                               output logic w, output logic x);
    logic [63:0] g;
    g = 64'h0000_0012_3460_0087;
    {e, c, w, x} = {g, 6'h00, 2'h0};
    case (i)
      0: {e, c, w} = {g | 64'h7FF0_0000_0000_0B00, 6'h04, 1'h1};
      1: c = 6'h02;
      2: e = g & ~64'h1;
      3: e = g & ~64'h80;
      4: e = g | 64'h2000;
      5: e = g | 64'h80_0000_0000;
      6: {e, c} = {g | 64'h80_0000_0000, 6'h20};
      7: e = g & ~64'h4;
      8: {e, c, w} = {g & ~64'h2, 6'h10, 1'h1};
      9: e = g & ~64'h2;
      10: {e, c, x} = {g | 64'h8000_0000_0000_0000, 6'h01, 1'h1};
      11: {e, x} = {g | 64'h8000_0000_0000_0000, 1'h1};
      12: {e, c} = {g | 64'h1118, 6'h08};
      default: ;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each answer
  // outputs are unknown before the first reset edge, so only watch once out of reset
  always @(posedge clk) begin
    if (rst_n === 1'h1) begin
      if (rd_pend) chk(reg_rdata, rq.pop_front());
      rd_pend = reg_rd;
      if (rsp_valid !== 1'h0 && eq.size() == 0) chk(rsp_valid, 64'h0);
      else if (rsp_valid === 1'h1) begin
        got = eq.pop_front();
        chk(rsp_fault, got.fault);
        chk(rsp_denied, got.denied);
        chk(rsp_addr, got.addr);
        chk(guest, got.guest);
        chk(mem_idx, got.idx);
        chk(wb_valid, got.wbv);
        chk(wb_entry, got.wbe);
      end else chk({rsp_fault, rsp_denied, wb_valid}, 64'h0);
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("MISMATCH t=%0t run did not finish", $time);
    give_verdict();
  end
  initial begin
    void'($urandom(32'hC4A6));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_FAULTS, 32'h0);
    rd(8'h0C, 32'h0);
    wr(REG_CTRL, 32'hFFFF_FFFF);
    rd(REG_CTRL, 32'h3F);
    wr(REG_STATUS, 32'hF);
    rd(REG_STATUS, 32'h0);
    $display("register map test done");
    for (int i = 0; i < 14; i++) begin
      if (i < 13) begin
        pick(i, e, c, w, x);
        tm.mem[i] = e;
        wr(REG_CTRL, {26'h0, c});
      end else {w, x} = 2'h0;
      walk(i < 13 ? 4'(i) : 4'h0, w, x, r);
      idle();
      rd(REG_STATUS, {28'h0, r.wbv, r.denied, r.fault && !r.np, r.np});
    end
    $display("directed walk test done");
    wr(REG_FAULTS, 32'h0);
    nfault = 0;
    for (int i = 0; i < 96; i++) begin
      if (i % 16 == 0) begin
        idle();
        wr(REG_CTRL, 32'($urandom_range(63)));
      end
      e = {$urandom, $urandom};
      if ($urandom_range(3) != 0) e = (e & ~64'h000F_C000_001F_E000) | 64'h81;
      tm.mem[i % 16] = e;
      walk(4'(i % 16), 1'($urandom), 1'($urandom), r);
    end
    idle();
    rd(REG_FAULTS, 32'(nfault));
    for (int t = 0; t < 20 && (eq.size() + rq.size()) > 0; t++) @(posedge clk);
    if ((eq.size() + rq.size()) > 0) chk(64'(eq.size() + rq.size()), 64'h0);
    $display("random walk test done");
    give_verdict();
  end
endmodule // lpd_leaf_decoder_tb_top
